// [design/host_bus_strap_and_map.v]
`timescale 1ns/10ps
`include "strap_map_consts.vh"
// Function
// - Capture seven straps as reset releases
// - All-low mode straps select generic big-endian
// - Wait polarity strap sets wait level
// - Divide strap selects half or full clock
// - Block select low registers, high buffer
// - Upper address bits ignored, blocks alias
// - Wait output holds host until done
module host_bus_strap_and_map #(
  parameter REG_AW = 6,
  parameter BUF_AW = 8
) (
  input wire clk,
  input wire rst_n,
  input wire [6:0] straps,
  input wire cs_n,
  input wire [`ADDR_WIDTH-1:0] addr,
  input wire we0_n,
  input wire we1_n,
  input wire rd_lo_n,
  input wire rd_hi_n,
  input wire [15:0] data_in,
  output reg [15:0] data_out,
  output reg data_oe,
  output reg wait_out,
  output reg generic1_be_mode,
  output reg wait_active_high,
  output reg bus_clk_div2,
  output reg reserved_ok,
  output reg bus_clk_en
);
  localparam ST_IDLE = 2'h0;
  localparam ST_BUSY = 2'h1;
  localparam ST_DONE = 2'h2;
  localparam ST_HOLD = 2'h3;

  // ==========================================
  // Strap capture
  reg [6:0] strap_q;
  reg captured_q;
  reg [6:0] ss1_q;
  reg [6:0] ss2_q;
  reg [6:0] ss3_q;

  // Strap pins are asynchronous: three stages, kept free of reset so that
  // they already hold the settled strap levels when reset releases
  always @(posedge clk) begin
    ss1_q <= straps;
    ss2_q <= ss1_q;
    ss3_q <= ss2_q;
  end

  // Taken once, on the first edge after release where stages two and three
  // agree, then frozen until the next reset
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      strap_q <= `STRAP_RESET_VALUE;
      captured_q <= 1'b0;
    end else if (!captured_q && (ss2_q == ss3_q)) begin
      strap_q <= ss3_q;
      captured_q <= 1'b1;
    end
  end

  // Decoded configuration outputs
  function is_generic1;
    input [6:0] s;
    begin
      is_generic1 = ({s[`STRAP_ENDIAN], s[`STRAP_BUS_SEL_MSB:`STRAP_BUS_SEL_LSB]} == `MODE_GENERIC1_BE);
    end
  endfunction

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      generic1_be_mode <= 1'b0;
      wait_active_high <= 1'b0;
      bus_clk_div2 <= 1'b0;
      reserved_ok <= 1'b0;
    end else begin
      generic1_be_mode <= captured_q & is_generic1(strap_q);
      wait_active_high <= strap_q[`STRAP_WAIT_POL];
      bus_clk_div2 <= strap_q[`STRAP_CLK_DIV];
      reserved_ok <= captured_q & strap_q[`STRAP_RESERVED];
    end
  end

  // ==========================================
  // Internal bus clock enable: every cycle or every other cycle
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_clk_en <= 1'b0;
    end else if (strap_q[`STRAP_CLK_DIV]) begin
      bus_clk_en <= ~bus_clk_en;
    end else begin
      bus_clk_en <= 1'b1;
    end
  end

  // ==========================================
  // Host pin synchronisers: three stages, change accepted when 2 and 3 agree
  localparam SW = 5 + 16 + `ADDR_WIDTH;
  wire [SW-1:0] pin_raw;
  reg [SW-1:0] s1_q;
  reg [SW-1:0] s2_q;
  reg [SW-1:0] s3_q;
  reg [SW-1:0] pin_q;
  assign pin_raw = {cs_n, we0_n, we1_n, rd_lo_n, rd_hi_n, data_in, addr};

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= {5'h1f, {(SW-5){1'b0}}};
      s2_q <= {5'h1f, {(SW-5){1'b0}}};
      s3_q <= {5'h1f, {(SW-5){1'b0}}};
      pin_q <= {5'h1f, {(SW-5){1'b0}}};
    end else begin
      s1_q <= pin_raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
      // Per bit: adopt only when stages two and three agree
      pin_q <= (pin_q & ~(s2_q ~^ s3_q)) | (s2_q & (s2_q ~^ s3_q));
    end
  end

  wire cs_s = ~pin_q[SW-1];
  wire we0_s = ~pin_q[SW-2];
  wire we1_s = ~pin_q[SW-3];
  wire rd_s = ~pin_q[SW-4] & ~pin_q[SW-5];
  wire [15:0] din_s = pin_q[`ADDR_WIDTH+15:`ADDR_WIDTH];
  wire [`ADDR_WIDTH-1:0] addr_s = pin_q[`ADDR_WIDTH-1:0];
  wire wr_s = we0_s | we1_s;

  // ==========================================
  // Address decode: bits above the block select are never looked at
  wire buf_sel = addr_s[`BLOCK_SEL_BIT];
  wire [`BLOCK_OFFSET_WIDTH-1:0] offs = addr_s[`BLOCK_OFFSET_WIDTH-1:0];
  // Word index within each block; byte bit 0 selects nothing on a 16-bit port
  wire [REG_AW-1:0] reg_idx = offs[REG_AW:1];
  wire [BUF_AW-1:0] buf_idx = offs[BUF_AW:1];

  // ==========================================
  // Access sequencer
  reg [1:0] state_q;
  reg [`WAIT_CNT_WIDTH-1:0] cnt_q;
  reg wr_pulse_q;
  reg sel_buf_q;
  wire [15:0] reg_rd;
  wire [15:0] buf_rd;

  // The device holds off the host a fixed number of cycles; this stands in
  // for arbitration against display refresh, which lives elsewhere.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      cnt_q <= {`WAIT_CNT_WIDTH{1'b0}};
      wr_pulse_q <= 1'b0;
      sel_buf_q <= 1'b0;
    end else begin
      wr_pulse_q <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (cs_s && (rd_s || wr_s) && generic1_be_mode) begin
            state_q <= ST_BUSY;
            cnt_q <= `ACCESS_WAIT_CYCLES;
            sel_buf_q <= buf_sel;
          end
        end
        ST_BUSY: begin
          if (cnt_q == {`WAIT_CNT_WIDTH{1'b0}}) begin
            state_q <= ST_DONE;
            wr_pulse_q <= wr_s;
          end else begin
            cnt_q <= cnt_q - {{(`WAIT_CNT_WIDTH-1){1'b0}}, 1'b1};
          end
        end
        ST_DONE: begin
          state_q <= ST_HOLD;
        end
        ST_HOLD: begin
          // Wait for the host to end the strobe before taking another access
          if (!(cs_s && (rd_s || wr_s))) begin
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Wait output: asserted while busy, in the captured polarity
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_out <= 1'b1;
    end else begin
      wait_out <= (((state_q == ST_IDLE) && cs_s && (rd_s || wr_s) && generic1_be_mode)
                   || (state_q == ST_BUSY)) ~^ strap_q[`STRAP_WAIT_POL];
    end
  end

  // Read data drive: big-endian lanes already match the 16-bit pins
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      data_out <= 16'h0000;
      data_oe <= 1'b0;
    end else begin
      data_oe <= cs_s & rd_s & (state_q != ST_IDLE);
      data_out <= sel_buf_q ? buf_rd : reg_rd;
    end
  end

  access_store #(.AW(REG_AW)) u_regs (
    .clk(clk),
    .wr_en(wr_pulse_q & ~sel_buf_q),
    .wr_bytes({we1_s, we0_s}),
    .addr(reg_idx),
    .wr_data(din_s),
    .rd_data(reg_rd)
  );

  access_store #(.AW(BUF_AW)) u_buf (
    .clk(clk),
    .wr_en(wr_pulse_q & sel_buf_q),
    .wr_bytes({we1_s, we0_s}),
    .addr(buf_idx),
    .wr_data(din_s),
    .rd_data(buf_rd)
  );
endmodule

// [design/strap_map_consts.vh]
`ifndef STRAP_MAP_CONSTS_VH
`define STRAP_MAP_CONSTS_VH
// Strap vector bit positions
`define STRAP_BUS_SEL_LSB 0
`define STRAP_BUS_SEL_MSB 2
`define STRAP_RESERVED 3
`define STRAP_ENDIAN 4
`define STRAP_WAIT_POL 5
`define STRAP_CLK_DIV 6
`define STRAP_WIDTH 7
// Bus mode codes formed from endian strap and bus select straps
`define MODE_GENERIC1_BE 4'h0
// Reset values of captured straps: generic mode one, active low wait, no divide
`define STRAP_RESET_VALUE 7'h08
// Address map
`define ADDR_WIDTH 21
`define BLOCK_SEL_BIT 18
`define BLOCK_OFFSET_WIDTH 18
// Wait states inserted before acknowledge on each access
`define ACCESS_WAIT_CYCLES 4'h2
`define WAIT_CNT_WIDTH 4
`endif

// [design/access_store.v]
`timescale 1ns/10ps
// ==========================================
// Small word store with registered read data
module access_store #(
  parameter AW = 8
) (
  input wire clk,
  input wire wr_en,
  input wire [1:0] wr_bytes,
  input wire [AW-1:0] addr,
  input wire [15:0] wr_data,
  output reg [15:0] rd_data
);
  reg [15:0] mem [0:(1<<AW)-1];

  // Byte lane writes and registered read; no reset on storage
  always @(posedge clk) begin
    if (wr_en && wr_bytes[0]) begin
      mem[addr][7:0] <= wr_data[7:0];
    end
    if (wr_en && wr_bytes[1]) begin
      mem[addr][15:8] <= wr_data[15:8];
    end
    rd_data <= mem[addr];
  end
endmodule

// [test/strap_map_asserts.sv]
`timescale 1ns/10ps
// =====
// Strap capture and wait checks
module strap_map_asserts (
  input wire clk,
  input wire rst_n,
  input wire [6:0] straps,
  input wire wait_out,
  input wire generic1_be_mode,
  input wire wait_active_high,
  input wire bus_clk_div2,
  input wire reserved_ok,
  input wire bus_clk_en
);
  reg [1:0] cnt_q;
  reg [6:0] cap_q;
  wire done = cnt_q == 2'h3;
  wire busy = wait_out == wait_active_high;
  // Own strap copy; waits for edge 3 so the design's output register has settled
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 2'h0;
      cap_q <= 7'h00;
    end else begin
      if (!done) cnt_q <= cnt_q + 2'h1;
      if (cnt_q == 2'h0) cap_q <= straps;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_cap;
    done |-> reserved_ok == cap_q[3] && bus_clk_div2 == cap_q[6];
  endproperty
  a_cap: assert property (p_cap) else $error("strap capture wrong");
  property p_mode;
    done |-> generic1_be_mode == ({cap_q[4], cap_q[2:0]} == 4'h0);
  endproperty
  a_mode: assert property (p_mode) else $error("mode decode wrong");
  property p_refuse;
    done && !generic1_be_mode |-> !busy;
  endproperty
  a_refuse: assert property (p_refuse) else $error("wait in other mode");
  property p_pol;
    done |-> wait_active_high == cap_q[5];
  endproperty
  a_pol: assert property (p_pol) else $error("wait polarity wrong");
  property p_div2;
    done && bus_clk_div2 |=> bus_clk_en != $past(bus_clk_en);
  endproperty
  a_div2: assert property (p_div2) else $error("half rate enable stuck");
  property p_div1;
    done && !bus_clk_div2 |-> bus_clk_en;
  endproperty
  a_div1: assert property (p_div1) else $error("full rate enable low");
  property p_wait;
    done && busy |-> ##[1:8] !busy;
  endproperty
  a_wait: assert property (p_wait) else $error("wait never released");
  property p_hold;
    done |=> $stable({generic1_be_mode, wait_active_high, bus_clk_div2, reserved_ok});
  endproperty
  a_hold: assert property (p_hold) else $error("config moved");
  c_div2: cover property (done && bus_clk_div2);
  c_busy: cover property (done && busy);
  c_refuse: cover property (done && !generic1_be_mode);
endmodule

// [test/host_cpu_model.sv]
`timescale 1ns/10ps
// =====
// Host processor, one 16-bit port, no burst, ack only from wait
module host_cpu_model (
  input wire clk,
  input wire pol,
  input wire wait_out,
  input wire [15:0] data_out,
  input wire data_oe,
  output reg cs_n,
  output reg [20:0] addr,
  output reg we0_n,
  output reg we1_n,
  output reg rd_lo_n,
  output reg rd_hi_n,
  output reg [15:0] data_in,
  output reg oe_seen
);
  // Idle bus; upper address bits left undecoded on purpose
  initial begin
    {cs_n, we0_n, we1_n, rd_lo_n, rd_hi_n} = 5'h1f;
    addr = 21'h000000;
    data_in = 16'h0000;
    oe_seen = 1'b0;
  end
  // Strobes held until wait drops; released bus shows inverted data
  task access(input wr, input [1:0] be, input [20:0] a, input [15:0] d, output [15:0] q, output ok);
    integer n;
    begin
      n = 0;
      @(negedge clk);
      cs_n = 1'b0;
      addr = a;
      data_in = d;
      we0_n = !(wr && be[0]);
      we1_n = !(wr && be[1]);
      rd_lo_n = wr;
      rd_hi_n = wr;
      while (wait_out !== pol && n < 12) begin
        @(negedge clk);
        n = n + 1;
      end
      ok = n < 12;
      n = 0;
      while (wait_out === pol && n < 12) begin
        @(negedge clk);
        n = n + 1;
      end
      ok = ok && n < 12;
      q = data_out;
      oe_seen = data_oe;
      {cs_n, we0_n, we1_n, rd_lo_n, rd_hi_n} = 5'h1f;
      data_in = ~d;
      repeat (6) @(negedge clk);
    end
  endtask
endmodule

// [test/tb_host_bus_strap_and_map.sv]
`timescale 1ns/10ps
// =====
// Strap, map and wait bench
module tb_host_bus_strap_and_map;
  reg clk, rst_n, pol, ok;
  reg [6:0] straps;
  reg [15:0] q;
  wire cs_n, we0_n, we1_n, rd_lo_n, rd_hi_n, wait_out, mode, wpol, div2, res, ben, oe, oe_seen;
  wire [20:0] addr;
  wire [15:0] data_in, data_out;
  integer mismatches, checked;
  host_bus_strap_and_map #(.REG_AW(6), .BUF_AW(8)) uut (.clk(clk), .rst_n(rst_n), .straps(straps),
    .cs_n(cs_n), .addr(addr), .we0_n(we0_n), .we1_n(we1_n), .rd_lo_n(rd_lo_n), .rd_hi_n(rd_hi_n),
    .data_in(data_in), .data_out(data_out), .data_oe(oe), .wait_out(wait_out), .generic1_be_mode(mode),
    .wait_active_high(wpol), .bus_clk_div2(div2), .reserved_ok(res), .bus_clk_en(ben));
  host_cpu_model host (.clk(clk), .pol(pol), .wait_out(wait_out), .data_out(data_out), .data_oe(oe),
    .cs_n(cs_n), .addr(addr), .we0_n(we0_n), .we1_n(we1_n), .rd_lo_n(rd_lo_n), .rd_hi_n(rd_hi_n),
    .data_in(data_in), .oe_seen(oe_seen));
  // 20 MHz clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task check(input string nm, input [15:0] e, input [15:0] g);
    begin
      checked = checked + 1;
      if (g !== e) begin
        mismatches = mismatches + 1;
        $display("MISMATCH %s exp %h got %h", nm, e, g);
      end
    end
  endtask
  // Straps stay put across the release edge so capture is unambiguous
  task do_reset(input [6:0] s, input p);
    begin
      @(negedge clk);
      rst_n = 1'b0;
      straps = s;
      pol = p;
      repeat (4) @(negedge clk);
      rst_n = 1'b1;
      repeat (3) @(negedge clk);
    end
  endtask
  task wr(input [1:0] be, input [20:0] a, input [15:0] d);
    host.access(1'b1, be, a, d, q, ok);
    check("write ack", 16'h0001, {15'h0000, ok});
    check("write drive", 16'h0000, {15'h0000, oe_seen});
  endtask
  task rd(input [20:0] a, input [15:0] e);
    host.access(1'b0, 2'h0, a, 16'h0000, q, ok);
    check("read ack", 16'h0001, {15'h0000, ok});
    check("read data", e, q);
    check("read drive", 16'h0001, {15'h0000, oe_seen});
    check("drive off", 16'h0000, {15'h0000, oe});
  endtask
  task stop_test;
    $display("Counts: %0d checked, %0d mismatches", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Watchdog at 4000 cycles, far beyond the few hundred cycles the tests need
  initial begin
    #200000;
    mismatches = mismatches + 1;
    stop_test;
  end
  // Main sequence
  initial begin
    {rst_n, pol, straps, mismatches, checked} = 0;
    do_reset(7'h68, 1'b1);
    check("config", 16'h000f, {12'h000, mode, wpol, div2, res});
    wr(2'h3, 21'h000010, 16'ha5c3);
    wr(2'h3, 21'h040010, 16'h3c5a);
    rd(21'h180010, 16'ha5c3);
    rd(21'h1c0010, 16'h3c5a);
    wr(2'h2, 21'h000010, 16'h77ee);
    rd(21'h000010, 16'h77c3);
    straps = 7'h01;
    rd(21'h040010, 16'h3c5a);
    check("held", 16'h000f, {12'h000, mode, wpol, div2, res});
    $display("Test A done");
    do_reset(7'h08, 1'b0);
    check("low pol", 16'h0009, {12'h000, mode, wpol, div2, res});
    wr(2'h3, 21'h040020, 16'h1234);
    rd(21'h0c0020, 16'h1234);
    $display("Test B done");
    do_reset(7'h09, 1'b0);
    check("other mode", 16'h0001, {12'h000, mode, wpol, div2, res});
    host.access(1'b1, 2'h3, 21'h000010, 16'h5555, q, ok);
    check("refused", 16'h0000, {15'h0000, ok});
    $display("Test C done");
    stop_test;
  end
endmodule
bind host_bus_strap_and_map strap_map_asserts chk (.clk(clk), .rst_n(rst_n), .straps(straps), .wait_out(wait_out),
  .generic1_be_mode(generic1_be_mode), .wait_active_high(wait_active_high), .bus_clk_div2(bus_clk_div2),
  .reserved_ok(reserved_ok), .bus_clk_en(bus_clk_en));
